//--- pkg/cfg_params.svh
// Constants for the configuration pointer, data window and register attributes
`ifndef CFG_PARAMS_SVH
`define CFG_PARAMS_SVH

// I/O dword addresses (byte address bits 15:2) of the pointer and the window
`define CFG_PTR_DW 14'h033E
`define CFG_DATA_DW 14'h033F

// Pointer fields
`define PTR_EN_BIT 31
`define PTR_BUS_MSB 23
`define PTR_BUS_LSB 16
`define PTR_DEV_MSB 15
`define PTR_DEV_LSB 11
`define PTR_FN_MSB 10
`define PTR_FN_LSB 8
`define PTR_REG_MSB 7
`define PTR_REG_LSB 2
`define PTR_WR_MASK 32'h80FF_FFFC
`define PTR_RESET 32'h0000_0000

// Device numbers of the three internal register sets on bus 0
`define DEV_HUB 5'h00
`define DEV_GFX 5'h01
`define DEV_NET 5'h03

// Implemented block: register dwords 10h..13h (byte offsets 40h..4Fh)
`define BLK_BASE_HI 4'h4

// Dword 0: strap field, control field, lock bit, clear-on-one status
`define STRAP_LSB 0
`define LOCK_BIT 8
`define RW_MASK0 32'h0000_01F0
`define WC_MASK0 32'h00FF_0000
`define STRAP_MASK0 32'h0000_0003
`define DEF_0 32'h0000_0010
// Dword 1: low half lockable, high half plain read/write
`define RW_MASK1 32'hFFFF_0000
`define LK_MASK1 32'h0000_FFFF
`define DEF_1 32'h0000_0000
// Dword 2: write-once
`define WO_MASK2 32'hFFFF_FFFF
`define DEF_2 32'h0000_0000
// Dword 3: read-only identity word
`define DEF_3 32'h0000_0001

`endif

//--- pkg/cfg_pkg.sv
// Types and shared helpers of the configuration register block
package cfg_pkg;

  // Access sequencer, Gray coded along idle -> exec -> ack
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ACK = 2'b11
  } io_state_t;

  // Expand four byte enables to a 32-bit lane mask, lane 0 in the low byte
  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : byte_mask

endpackage : cfg_pkg

//--- core/cfg_io_decode.sv
// Decodes a host I/O access against the pointer and the data window
`timescale 1ns/10ps
`default_nettype none
`include "cfg_params.svh"
module cfg_io_decode
  import cfg_pkg::*;
(
  input wire logic [15:2] addr, // Dword address of the access
  input wire logic [3:0] be, // Byte enables
  input wire logic [31:0] ptr, // Current pointer contents
  output logic ptr_hit, // Access falls on the pointer
  output logic ptr_full, // Pointer access is a whole dword
  output logic data_hit, // Access falls on the data window
  output logic int_hit, // Window maps onto an internal set
  output logic [1:0] set_idx, // Selected register set
  output logic blk_hit, // Register lies in the implemented block
  output logic [1:0] dw_idx // Dword inside the block
);

  logic dev_ok; // Device number names one of the three sets
  logic [4:0] dev; // Device field of the pointer

  // Pure decode; no state here
  always_comb begin
    dev = ptr[`PTR_DEV_MSB:`PTR_DEV_LSB];
    ptr_hit = (addr == `CFG_PTR_DW);
    ptr_full = (be == 4'hF);
    data_hit = (addr == `CFG_DATA_DW);
    dev_ok = 1'b1;
    set_idx = 2'h0;
    unique case (dev)
      `DEV_HUB: set_idx = 2'h0;
      `DEV_GFX: set_idx = 2'h1;
      `DEV_NET: set_idx = 2'h2;
      default: dev_ok = 1'b0; // Outside the three sets
    endcase
    int_hit = ptr[`PTR_EN_BIT] && (ptr[`PTR_BUS_MSB:`PTR_BUS_LSB] == 8'h00) &&
              (ptr[`PTR_FN_MSB:`PTR_FN_LSB] == 3'h0) && dev_ok;
    blk_hit = (ptr[`PTR_REG_MSB:`PTR_REG_LSB+2] == `BLK_BASE_HI);
    dw_idx = ptr[`PTR_REG_LSB+1:`PTR_REG_LSB];
  end

endmodule : cfg_io_decode
`default_nettype wire

//--- core/cfg_bit_merge.sv
// Next value of one configuration dword under the per-bit access attributes
`timescale 1ns/10ps
`default_nettype none
module cfg_bit_merge
  import cfg_pkg::*;
(
  input wire logic [31:0] old_val, // Present contents
  input wire logic wr_en, // A host write lands on this dword
  input wire logic [31:0] wdata, // Host write data
  input wire logic [3:0] be, // Byte enables of the write
  input wire logic [31:0] rw_mask, // Plain read/write bits
  input wire logic [31:0] wc_mask, // Write-one-to-clear bits
  input wire logic [31:0] wo_open, // Write-once bits not yet written
  input wire logic [31:0] lk_mask, // Lockable bits
  input wire logic locked, // Lock bit of the set is on
  input wire logic [31:0] set_bits, // Hardware events, set wins over clear
  output logic [31:0] next_val // Value to store
);

  logic [31:0] lanes; // Bits the write touches
  logic [31:0] wr_ok; // Bits that take the written value

  // Anything not in a writable mask keeps its value, which makes RO bits immune
  always_comb begin
    lanes = wr_en ? byte_mask(be) : 32'h0000_0000;
    wr_ok = lanes & (rw_mask | wo_open | (locked ? 32'h0000_0000 : lk_mask));
    next_val = (old_val & ~wr_ok) | (wdata & wr_ok);
    next_val = next_val & ~(wdata & lanes & wc_mask);
    next_val = next_val | (set_bits & wc_mask);
  end

endmodule : cfg_bit_merge
`default_nettype wire

//--- core/cfg_register_bank.sv
// Configuration register bank behind the I/O pointer and data window
//
// Function
// - Byte, word or dword access on registers
// - Pointer taken only as full dword
// - Lowest byte lane holds least significant byte
// - Read-only bits ignore writes entirely
// - Writing one clears bit, zero keeps
// - Write-once bit freezes after first write
// - Lockable bit freezes once lock set
// - Reserved locations still complete the cycle
// - Reserved locations read as all zeros
// - Writes to reserved locations change nothing
// - Reset loads defaults, some from straps
// - Ports and registers reached through I/O
// - Pointer-and-window configuration access, mechanism one
// - Three register sets: hub, graphics, network
// - Pointer at 0CF8h, window at 0CFCh
// - Window maps only when pointer bit31 set
// - Full reset returns every bit default
`timescale 1ns/10ps
`default_nettype none
`include "cfg_params.svh"
module cfg_register_bank
  import cfg_pkg::*;
#(
  parameter int STRAP_W = 2, // Width of the strapped default field
  parameter int EVENT_W = 8 // Status events per register set
) (
  input wire logic clock, // Core clock, 40 MHz
  input wire logic rstn, // Hub reset, active low, asynchronous
  input wire logic power_good_input, // Power good, low during a full reset
  input wire logic [STRAP_W-1:0] strap_in, // Strap pins for default values
  input wire logic [15:2] io_addr, // Host I/O dword address
  input wire logic [3:0] io_be, // Host byte enables
  input wire logic [31:0] io_wdata, // Host write data
  input wire logic io_rd, // Host read strobe, one cycle
  input wire logic io_wr, // Host write strobe, one cycle
  input wire logic [3*EVENT_W-1:0] hw_event, // Status events, set by set
  output logic [31:0] io_rdata, // Read data, valid with io_ack
  output logic io_ack, // Access complete, one cycle
  output logic [2:0] lock_state, // Lock bit of each register set
  output logic [11:0] set_ctrl // Control field of each register set
);

  // Reset release through two flops
  logic rst_meta_reg; // First stage, read only by the second
  logic rst_sync_reg; // Synchronised reset release
  logic rstn_int; // Internal active-low reset

  // Host side
  io_state_t state_reg; // Access sequencer
  logic [15:2] req_addr_reg; // Latched address
  logic [3:0] req_be_reg; // Latched byte enables
  logic [31:0] req_wdata_reg; // Latched write data
  logic req_wr_reg; // Latched access is a write
  logic [31:0] ptr_reg; // Configuration pointer
  logic [31:0] rdata_reg; // Read data register
  logic ack_reg; // Completion pulse

  // Register storage
  logic [31:0] cfg_reg [3][4]; // Three sets of four dwords
  logic [31:0] cfg_next [3][4]; // Merged next values
  logic [31:0] wo_done_reg [3]; // Write-once bits already written
  logic [STRAP_W-1:0] strap_reg; // Captured strap levels
  logic init_reg; // Strap default still to be loaded

  // Decode outputs
  logic ptr_hit; // Pointer addressed
  logic ptr_full; // Whole dword
  logic data_hit; // Window addressed
  logic int_hit; // Window maps internally
  logic [1:0] set_idx; // Target set
  logic blk_hit; // Target inside implemented block
  logic [1:0] dw_idx; // Target dword
  logic win_wr; // Write through the window lands on storage

  // Attribute masks per dword index
  // The lock bit guards itself, so it is taken out of the plain read/write set
  // and listed as lockable; otherwise software could simply unlock again
  function automatic logic [31:0] rw_of(input int d);
    unique case (d)
      0: rw_of = `RW_MASK0 & ~(32'h0000_0001 << `LOCK_BIT);
      1: rw_of = `RW_MASK1;
      default: rw_of = 32'h0000_0000;
    endcase
  endfunction : rw_of

  function automatic logic [31:0] wc_of(input int d);
    wc_of = (d == 0) ? `WC_MASK0 : 32'h0000_0000;
  endfunction : wc_of

  function automatic logic [31:0] wo_of(input int d);
    wo_of = (d == 2) ? `WO_MASK2 : 32'h0000_0000;
  endfunction : wo_of

  // Once the lock bit is on, it and the low half of dword 1 freeze together
  function automatic logic [31:0] lk_of(input int d);
    unique case (d)
      0: lk_of = 32'h0000_0001 << `LOCK_BIT;
      1: lk_of = `LK_MASK1;
      default: lk_of = 32'h0000_0000;
    endcase
  endfunction : lk_of

  function automatic logic [31:0] def_of(input int d);
    unique case (d)
      0: def_of = `DEF_0;
      1: def_of = `DEF_1;
      2: def_of = `DEF_2;
      default: def_of = `DEF_3;
    endcase
  endfunction : def_of

  // Two-flop release of the hub reset; assertion is immediate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rstn_int = rst_sync_reg;

  // Decoding is always against the latched request and the live pointer
  cfg_io_decode u_decode (
    .addr(req_addr_reg),
    .be(req_be_reg),
    .ptr(ptr_reg),
    .ptr_hit(ptr_hit),
    .ptr_full(ptr_full),
    .data_hit(data_hit),
    .int_hit(int_hit),
    .set_idx(set_idx),
    .blk_hit(blk_hit),
    .dw_idx(dw_idx)
  );

  // A reserved location inside a set has no storage, so it never writes
  assign win_wr = (state_reg == ST_EXEC) && req_wr_reg && data_hit && int_hit && blk_hit;

  // Sequencer: take, execute, acknowledge; busy cycles ignore new strobes
  // A strobe during exec or ack is dropped silently, so the host must space requests
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (io_rd || io_wr) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: state_reg <= ST_ACK;
        ST_ACK: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE; // Unused code 2'b10
      endcase
    end
  end

  // Latch the request; a write wins if both strobes arrive together
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      req_addr_reg <= 14'h0000;
      req_be_reg <= 4'h0;
      req_wdata_reg <= 32'h0000_0000;
      req_wr_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && (io_rd || io_wr)) begin
      req_addr_reg <= io_addr;
      req_be_reg <= io_be;
      req_wdata_reg <= io_wdata;
      req_wr_reg <= io_wr;
    end
  end

  // Pointer: only a full dword write changes it; no read-merge needed
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      ptr_reg <= `PTR_RESET;
    end else if (state_reg == ST_EXEC && req_wr_reg && ptr_hit && ptr_full) begin
      ptr_reg <= req_wdata_reg & `PTR_WR_MASK;
    end
  end

  // Strap levels flow through while power is not good, then hold
  // A warm reset keeps the captured levels, as the pins may be driven by then
  always_ff @(posedge clock) begin
    if (!power_good_input) begin
      strap_reg <= strap_in;
    end
  end

  // One cycle after release the strapped default field is loaded
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  // Write-once memory survives a warm reset; only power-up clears it
  // No asynchronous reset here on purpose: the hub reset must not reopen these bits
  always_ff @(posedge clock) begin
    if (!power_good_input) begin
      wo_done_reg <= '{default: 32'h0000_0000};
    end else if (win_wr && dw_idx == 2'h2) begin
      wo_done_reg[set_idx] <= wo_done_reg[set_idx] |
                              (byte_mask(req_be_reg) & wo_of(2));
    end
  end

  // One merge per dword of each set
  for (genvar s = 0; s < 3; s++) begin : g_set
    for (genvar d = 0; d < 4; d++) begin : g_dw
      logic [31:0] ev_bits; // Events lined up with the status field
      logic [31:0] wo_open; // Write-once bits still open
      logic [31:0] hit_wr; // Write reaches this dword

      always_comb begin
        ev_bits = 32'h0000_0000;
        if (d == 0) begin
          ev_bits[23:16] = hw_event[s*EVENT_W +: EVENT_W];
        end
        wo_open = wo_of(d) & ~wo_done_reg[s];
        hit_wr = (win_wr && set_idx == 2'(s) && dw_idx == 2'(d)) ? 32'h1 : 32'h0;
      end

      cfg_bit_merge u_merge (
        .old_val(cfg_reg[s][d]),
        .wr_en(hit_wr[0]),
        .wdata(req_wdata_reg),
        .be(req_be_reg),
        .rw_mask(rw_of(d)),
        .wc_mask(wc_of(d)),
        .wo_open(wo_open),
        .lk_mask(lk_of(d)),
        .locked(cfg_reg[s][0][`LOCK_BIT]),
        .set_bits(ev_bits),
        .next_val(cfg_next[s][d])
      );

      // Storage; reset gives the constant default, straps follow on release
      always_ff @(posedge clock or negedge rstn_int) begin
        if (!rstn_int) begin
          cfg_reg[s][d] <= def_of(d);
        end else if (init_reg && d == 0) begin
          cfg_reg[s][d] <= (cfg_next[s][d] & ~`STRAP_MASK0) |
                           (32'(strap_reg) << `STRAP_LSB);
        end else begin
          cfg_reg[s][d] <= cfg_next[s][d];
        end
      end
    end
  end

  // Read data and completion; every decoded or undecoded access completes
  // Lanes the host did not enable read as zero, so narrow reads never leak
  // neighbouring bytes; a hang on an unknown address is never possible
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      ack_reg <= 1'b1;
      if (req_wr_reg) begin
        rdata_reg <= 32'h0000_0000;
      end else if (ptr_hit) begin
        rdata_reg <= ptr_full ? ptr_reg : 32'h0000_0000;
      end else if (data_hit && int_hit && blk_hit) begin
        rdata_reg <= cfg_reg[set_idx][dw_idx] & byte_mask(req_be_reg);
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end else begin
      ack_reg <= 1'b0;
    end
  end

  // Registered views of each set for the logic that uses them
  // They lag the storage by one cycle, which keeps every output on a flop
  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      lock_state <= 3'h0;
      set_ctrl <= 12'h000;
    end else begin
      for (int s = 0; s < 3; s++) begin
        lock_state[s] <= cfg_reg[s][0][`LOCK_BIT];
        set_ctrl[s*4 +: 4] <= cfg_reg[s][0][7:4];
      end
    end
  end

  assign io_rdata = rdata_reg;
  assign io_ack = ack_reg;

endmodule : cfg_register_bank
`default_nettype wire

//--- test/cfg_bank_props.sv
// Checker of the host access timing and read results
`timescale 1ns/10ps
`default_nettype none
`include "cfg_params.svh"
module cfg_bank_props
  import cfg_pkg::*;
#(
  parameter int STRAP_W = 2, // Strap width
  parameter int EVENT_W = 8 // Events per set
) (
  input wire logic clock, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic [15:2] io_addr, // Dword address
  input wire logic [3:0] io_be, // Byte enables
  input wire logic [31:0] io_wdata, // Write data
  input wire logic io_rd, // Read strobe
  input wire logic io_wr, // Write strobe
  input wire logic [31:0] io_rdata, // Read data
  input wire logic io_ack // Completion
);
  logic [1:0] busy_reg; // Cycles until idle again
  logic rd_reg; // Taken access is a read
  logic [15:2] a_reg; // Its address
  logic [3:0] be_reg; // Its enables
  logic [31:0] ptr_reg; // Pointer shadow
  logic take; // Request accepted
  logic win; // Window on a mapped set
  logic [31:0] lane; // Enabled lanes
  assign take = (io_rd | io_wr) & (busy_reg == 2'h0);
  assign win = rd_reg & (a_reg == `CFG_DATA_DW) & ptr_reg[31] & (ptr_reg[23:16] == 8'h00)
    & (ptr_reg[10:8] == 3'h0) & (ptr_reg[15:11] inside {`DEV_HUB, `DEV_GFX, `DEV_NET});
  assign lane = {{8{be_reg[3]}}, {8{be_reg[2]}}, {8{be_reg[1]}}, {8{be_reg[0]}}};
  // Track the access in flight; strobes while busy are ignored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 2'h0;
      rd_reg <= 1'b0;
      a_reg <= '0;
      be_reg <= 4'h0;
      ptr_reg <= `PTR_RESET;
    end else if (take) begin
      busy_reg <= 2'h2;
      rd_reg <= !io_wr;
      a_reg <= io_addr;
      be_reg <= io_be;
      if (io_wr && io_addr == `CFG_PTR_DW && io_be == 4'hF) begin
        ptr_reg <= io_wdata & `PTR_WR_MASK;
      end
    end else if (busy_reg != 2'h0) begin
      busy_reg <= busy_reg - 2'h1;
    end
  end
  ack_time_a: assert property (@(posedge clock) disable iff (!rstn)
    take |-> !io_ack ##2 io_ack) else $error("late ack");
  ack_only_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack |-> busy_reg == 2'h1 ##1 !io_ack) else $error("stray ack");
  wr_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && !rd_reg |-> io_rdata == 32'h0) else $error("write data");
  lane_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && rd_reg |-> (io_rdata & ~lane) == 32'h0) else $error("lane leak");
  ptr_read_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && rd_reg && a_reg == `CFG_PTR_DW |-> io_rdata == (be_reg == 4'hF ? ptr_reg : 32'h0))
    else $error("pointer");
  off_map_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && a_reg != `CFG_PTR_DW && a_reg != `CFG_DATA_DW |-> io_rdata == 32'h0)
    else $error("unmapped");
  win_off_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && rd_reg && a_reg == `CFG_DATA_DW && !ptr_reg[31] |-> io_rdata == 32'h0)
    else $error("window off");
  ro_word_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && win && ptr_reg[7:2] == 6'h13 |-> io_rdata == (`DEF_3 & lane))
    else $error("read only");
  rsvd_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    io_ack && win && ptr_reg[7:4] != `BLK_BASE_HI |-> io_rdata == 32'h0)
    else $error("reserved");
endmodule : cfg_bank_props
bind cfg_register_bank cfg_bank_props #(.STRAP_W(STRAP_W), .EVENT_W(EVENT_W)) i_props (
  .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata),
  .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata), .io_ack(io_ack));
`default_nettype wire

//--- test/io_host_model.sv
// Host processor issuing I/O accesses to the pointer and window
`timescale 1ns/10ps
`default_nettype none
module io_host_model (
  input wire logic clock, // Core clock
  input wire logic [31:0] io_rdata, // Read data
  input wire logic io_ack, // Completion
  output var logic [15:2] io_addr, // Dword address
  output var logic [3:0] io_be, // Byte enables
  output var logic [31:0] io_wdata, // Write data
  output var logic io_rd, // Read strobe
  output var logic io_wr // Write strobe
);
  // Idle at time zero
  initial begin
    io_addr = '0;
    io_be = 4'h0;
    io_wdata = 32'h0;
    io_rd = 1'b0;
    io_wr = 1'b0;
  end
  // One access; pointer may be sent narrow, and the caller writes it without merging reserved bits
  // Vendor reserved places are read and written too; pointer written without merging
  task automatic xfer(input logic wr, input logic [15:2] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'hX;
    @(posedge clock);
    io_addr <= a;
    io_be <= be;
    io_wdata <= d;
    io_rd <= !wr;
    io_wr <= wr;
    @(posedge clock);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    for (int n = 0; n < 6 && !ok; n++) begin
      @(posedge clock);
      if (io_ack === 1'b1) begin
        q = io_rdata;
        ok = 1'b1;
      end
    end
    // Released lines show garbage, never the old value
    io_addr <= ~a;
    io_be <= ~be;
    io_wdata <= ~d;
  endtask : xfer
endmodule : io_host_model
`default_nettype wire

//--- test/config_register_access_rules_bench.sv
// Self-checking bench of the configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "cfg_params.svh"
module config_register_access_rules_bench;
  logic clock = 1'b0; // Core clock
  logic rstn = 1'b0; // Reset, active low
  logic power_good_input = 1'b0; // Power good
  logic [1:0] strap_in = 2'h0; // Strap levels
  logic [23:0] hw_event = 24'h0; // Status events
  logic [15:2] io_addr; // Host bus
  logic [3:0] io_be;
  logic [31:0] io_wdata;
  logic [31:0] io_rdata;
  logic io_rd;
  logic io_wr;
  logic io_ack;
  logic [2:0] lock_state; // Lock bits seen
  logic [11:0] set_ctrl; // Control fields seen
  int failures = 0; // Mismatches
  int total_checks = 0; // Comparisons
  int cycles = 0; // Hang guard
  logic [31:0] mv [3][4]; // Model contents per set
  logic [31:0] wo_set [3]; // Write-once bits used
  logic [4:0] dev [3] = '{`DEV_HUB, `DEV_GFX, `DEV_NET}; // Device of each set
  cfg_register_bank i_dut (.clock(clock), .rstn(rstn), .power_good_input(power_good_input),
    .strap_in(strap_in), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_rd(io_rd),
    .io_wr(io_wr), .hw_event(hw_event), .io_rdata(io_rdata), .io_ack(io_ack),
    .lock_state(lock_state), .set_ctrl(set_ctrl));
  io_host_model i_host (.clock(clock), .io_rdata(io_rdata), .io_ack(io_ack), .io_addr(io_addr),
    .io_be(io_be), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // A hang ends the run as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = 32'h0;
    for (int i = 0; i < 4; i++) if (be[i]) lanes[8*i +: 8] = 8'hFF;
  endfunction : lanes
  function automatic logic [31:0] ptrv(input int s, input logic [5:0] r);
    ptrv = {1'b1, 15'h0, dev[s], 3'h0, r, 2'b00};
  endfunction : ptrv
  task automatic acc(input logic wr, input logic [15:2] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
    logic ok;
    i_host.xfer(wr, a, be, d, q, ok);
    check("ack", 32'h1, {31'h0, ok});
  endtask : acc
  // Write through the window and update the model by attribute
  task automatic wreg(input int s, input logic [5:0] r, input logic [31:0] d,
      input logic [3:0] be);
    logic [31:0] q;
    logic [31:0] lm;
    logic [31:0] m;
    acc(1'b1, `CFG_PTR_DW, 4'hF, ptrv(s, r), q);
    acc(1'b1, `CFG_DATA_DW, be, d, q);
    lm = lanes(be);
    m = 32'h0;
    case (r)
      6'h10: begin
        mv[s][0] = mv[s][0] & ~(d & lm & `WC_MASK0);
        m = lm & (mv[s][0][8] ? 32'h0000_00F0 : `RW_MASK0);
      end
      6'h11: m = lm & (`RW_MASK1 | (mv[s][0][8] ? 32'h0 : `LK_MASK1));
      6'h12: begin
        m = lm & ~wo_set[s];
        wo_set[s] = wo_set[s] | lm;
      end
      default: m = 32'h0;
    endcase
    mv[s][r[1:0]] = (mv[s][r[1:0]] & ~m) | (d & m);
  endtask : wreg
  task automatic rreg(input int s, input logic [5:0] r, input logic [3:0] be, input string what);
    logic [31:0] q;
    acc(1'b1, `CFG_PTR_DW, 4'hF, ptrv(s, r), q);
    acc(1'b0, `CFG_DATA_DW, be, 32'h0, q);
    check(what, (r[5:2] == `BLK_BASE_HI) ? mv[s][r[1:0]] & lanes(be) : 32'h0, q);
  endtask : rreg
  // Full reset clears write-once memory too; warm keeps it
  task automatic do_reset(input logic full);
    if (rstn) begin
      @(posedge clock);
    end
    rstn <= 1'b0;
    power_good_input <= !full;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    power_good_input <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      mv[s] = '{`DEF_0 | {30'h0, strap_in}, `DEF_1, `DEF_2, `DEF_3};
      if (full) wo_set[s] = 32'h0;
    end
    repeat (4) @(posedge clock);
  endtask : do_reset
  initial begin
    logic [31:0] q;
    logic [31:0] d;
    void'($urandom(32'hC997));
    strap_in <= 2'($urandom());
    do_reset(1'b1);
    for (int s = 0; s < 3; s++) begin
      for (int r = 0; r < 4; r++) begin
        rreg(s, 6'(16 + r), 4'hF, "default");
      end
    end
    check("set_ctrl", 32'h111, {20'h0, set_ctrl});
    check("lock_state", 32'h0, {29'h0, lock_state});
    $display("test defaults done");
    d = $urandom();
    acc(1'b1, `CFG_PTR_DW, 4'hF, d, q);
    acc(1'b0, `CFG_PTR_DW, 4'hF, 32'h0, q);
    check("pointer", d & `PTR_WR_MASK, q);
    acc(1'b1, `CFG_PTR_DW, 4'h3, ~d, q);
    acc(1'b0, `CFG_PTR_DW, 4'h1, 32'h0, q);
    check("narrow pointer read", 32'h0, q);
    acc(1'b0, `CFG_PTR_DW, 4'hF, 32'h0, q);
    check("narrow pointer write", d & `PTR_WR_MASK, q);
    $display("test pointer done");
    d = $urandom();
    @(posedge clock);
    hw_event <= d[23:0];
    @(posedge clock);
    hw_event <= 24'h0;
    for (int s = 0; s < 3; s++) mv[s][0] = mv[s][0] | {8'h0, d[8*s +: 8], 16'h0};
    for (int s = 0; s < 3; s++) begin
      wreg(s, 6'h11, $urandom(), 4'hF);
      wreg(s, 6'h11, $urandom(), 4'h2);
      rreg(s, 6'h11, 4'hF, "lane write");
      rreg(s, 6'h11, 4'h4, "lane read");
      wreg(s, 6'h13, 32'hFFFF_FFFF, 4'hF);
      rreg(s, 6'h13, 4'hF, "read only");
      wreg(s, 6'h14, 32'hFFFF_FFFF, 4'hF);
      rreg(s, 6'h14, 4'hF, "reserved");
      rreg(s, 6'h0F, 4'hC, "reserved word");
      rreg(s, 6'h11, 4'hF, "after reserved");
      wreg(s, 6'h12, $urandom(), 4'h3);
      wreg(s, 6'h12, $urandom(), 4'hF);
      rreg(s, 6'h12, 4'hF, "write once");
      rreg(s, 6'h10, 4'hF, "status set");
      wreg(s, 6'h10, $urandom(), 4'h4);
      rreg(s, 6'h10, 4'hF, "status clear");
      wreg(s, 6'h10, 32'h0000_0100 | $urandom(), 4'h3);
      wreg(s, 6'h11, $urandom(), 4'hF);
      rreg(s, 6'h11, 4'hF, "locked");
      wreg(s, 6'h10, 32'h0000_0000, 4'h3);
      rreg(s, 6'h10, 4'hF, "lock holds");
    end
    check("lock_state", 32'h7, {29'h0, lock_state});
    check("set_ctrl", {20'h0, mv[2][0][7:4], mv[1][0][7:4], mv[0][0][7:4]},
      {20'h0, set_ctrl});
    $display("test attributes done");
    acc(1'b1, `CFG_PTR_DW, 4'hF, ptrv(0, 6'h11) & 32'h7FFF_FFFF, q);
    acc(1'b1, `CFG_DATA_DW, 4'hF, $urandom(), q);
    acc(1'b0, `CFG_DATA_DW, 4'hF, 32'h0, q);
    check("window off", 32'h0, q);
    rreg(0, 6'h11, 4'hF, "window off write");
    acc(1'b0, 14'h0100, 4'hF, 32'h0, q);
    check("unmapped", 32'h0, q);
    $display("test window done");
    do_reset(1'b0);
    wreg(0, 6'h12, 32'hFFFF_FFFF, 4'hF);
    rreg(0, 6'h12, 4'hF, "warm once");
    rreg(0, 6'h10, 4'hF, "warm default");
    do_reset(1'b1);
    wreg(0, 6'h12, 32'hA5A5_5A5A, 4'hF);
    rreg(0, 6'h12, 4'hF, "power up once");
    $display("test resets done");
    complete_run;
  end
endmodule : config_register_access_rules_bench
`default_nettype wire
